/* dsc_channel_ctrl.sv */
// per-channel enable, suspend and resume control with axi4-lite registers
// Function
// RQ1: entering suspend sets the channel suspend flag and may raise the interrupt.
// RQ2: block action 0x2 or 0x3 suspends after a block; stays enabled, leaves arbitration.
// RQ3: invalid fetched descriptor suspends the channel and sets fetch error.
// RQ4: only enabled channels suspend; requests to disabled ones change nothing.
// RQ5: resume on a suspended channel continues exactly where it stopped.
// RQ6: resume before suspend is remembered and skips the next suspend; here a fetch-error suspend is not skipped, only a software or block-action one.
// RQ7: event inputs exist only on the lowest-numbered channels.
// RQ8: software sets up events and event input enable; no-action gives no response.
// RQ9: software keeps the write-back base address 128-bit aligned.
// RQ10: a 4-bit channel select picks the channel the per-channel registers reach.
// RQ11: disabling mid-transfer keeps enable at 1 until burst ends and buffer empties.
// RQ12: writing 1 to enable enables the channel regardless of enable protection.
// RQ13: soft reset only while disabled; reads 1 while busy, then clears itself.
// RQ14: command field bits 25:24, 0 no action, 1 suspend, not enable-protected.
// RQ15: resume has its own code; the field returns to no action once taken.
// RQ16: software suspend takes effect at the next burst boundary.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_channel_ctrl import dsc_pkg::*; #(
	parameter int NCH = 16,
	parameter int NEV = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [`DSC_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`DSC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NCH-1:0] burst_busy,
	input wire logic [NCH-1:0] buf_empty,
	input wire logic [NCH-1:0] burst_end,
	input wire logic [NCH-1:0] block_end,
	input wire logic [NCH-1:0] desc_fetched,
	input wire logic [NCH-1:0] desc_valid,
	input wire logic [NEV-1:0] ev_in,
	output logic [NCH-1:0] ch_enable,
	output logic [NCH-1:0] ch_arb_ok,
	output logic [NCH-1:0] ch_abort,
	output logic [NEV-1:0] ev_trig,
	output logic [31:0] writeback_base_address,
	output logic irq
);
	logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
	logic [`DSC_AW-1:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [3:0] chsel_ff;
	logic [31:0] wrb_ff;
	logic [NCH-1:0] en_ff, dis_pend_ff, suspend_flag_ff, skip_ff, fetch_error_ff, rst_busy_ff;
	logic [NCH-1:0] abort_ff, event_input_enable_ff, flag_ff, mask_ff;
	dsc_cmd_t cmd_ff [NCH];
	logic [2:0] event_action_ff [NCH];
	logic [1:0] bact_ff [NCH];
	logic [NEV-1:0] ev_trig_ff;
	logic wr_do, rd_do, wr_a, wr_b, wr_bt, wr_mask, rd_clr;
	dsc_idx_t wr_idx, rd_idx;
	logic [NCH-1:0] sel_oh, go_suspend_flag, use_skip, cmd_take, is_resume;
	logic [31:0] rd_mux;

	// a register index that the map answers with okay
	function automatic logic is_mapped(input dsc_idx_t idx);
		case (idx)
			`DSC_IDX_CHSEL, `DSC_IDX_CHANNEL_CONTROL_A, `DSC_IDX_CHANNEL_CONTROL_B,
			`DSC_IDX_BLOCK_TRANSFER_CTL, `DSC_IDX_WRITEBACK_BASE_ADDRESS, `DSC_IDX_IRQMASK,
			`DSC_IDX_IRQFLAG, `DSC_IDX_STATE: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// write decode happens only once address and data are both held
	always_comb begin
		wr_do = ce && aw_ok_ff && w_ok_ff && !bvalid_ff;
		rd_do = ce && s_axi_arvalid && !rvalid_ff;
		wr_idx = awaddr_ff[`DSC_AW-1:2];
		rd_idx = s_axi_araddr[`DSC_AW-1:2];
		wr_a = wr_do && wr_idx == `DSC_IDX_CHANNEL_CONTROL_A && wstrb_ff[0];
		wr_b = wr_do && wr_idx == `DSC_IDX_CHANNEL_CONTROL_B;
		wr_bt = wr_do && wr_idx == `DSC_IDX_BLOCK_TRANSFER_CTL && wstrb_ff[0];
		wr_mask = wr_do && wr_idx == `DSC_IDX_IRQMASK && wstrb_ff[0];
		rd_clr = rd_do && rd_idx == `DSC_IDX_IRQFLAG;
		for (int i = 0; i < NCH; i++) begin
			sel_oh[i] = (chsel_ff == 4'(i)); // [RQ10]
		end
	end

	// suspend requests per channel; a fresh resume acts as a pending skip
	always_comb begin
		logic cmd_suspend_flag, req_soft, req_fetch_error, skip_eff;
		cmd_suspend_flag = 1'b0;
		req_soft = 1'b0;
		req_fetch_error = 1'b0;
		skip_eff = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			is_resume[i] = cmd_ff[i] == DSC_RESUME; // [RQ15]
			cmd_suspend_flag = cmd_ff[i] == DSC_SUSPEND && (burst_end[i] || !burst_busy[i]); // [RQ16]
			req_soft = en_ff[i] && !suspend_flag_ff[i] &&
				((block_end[i] && bact_ff[i][1]) || cmd_suspend_flag); // [RQ2] [RQ4]
			req_fetch_error = en_ff[i] && desc_fetched[i] && !desc_valid[i]; // [RQ3] [RQ4]
			skip_eff = skip_ff[i] || is_resume[i];
			go_suspend_flag[i] = req_fetch_error || (req_soft && !skip_eff);
			use_skip[i] = req_soft && skip_eff; // [RQ6]
			cmd_take[i] = is_resume[i] || cmd_suspend_flag || (cmd_ff[i] != DSC_NO_ACTION && !en_ff[i]);
		end
	end

	// write address and data are taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `DSC_RESP_OKAY;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_ok_ff <= 1'b0;
				w_ok_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= is_mapped(wr_idx) ? `DSC_RESP_OKAY : `DSC_RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// read answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= `DSC_RESP_OKAY;
		end else if (ce) begin
			if (rd_do) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_mux;
				rresp_ff <= is_mapped(rd_idx) ? `DSC_RESP_OKAY : `DSC_RESP_SLVERR;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// read mux; a select beyond the channel count reads zero
	always_comb begin
		int s;
		s = int'(chsel_ff);
		rd_mux = '0;
		if (rd_idx == `DSC_IDX_CHSEL) begin
			rd_mux[3:0] = chsel_ff;
		end else if (rd_idx == `DSC_IDX_WRITEBACK_BASE_ADDRESS) begin
			rd_mux = wrb_ff;
		end else if (s < NCH) begin
			case (rd_idx)
				`DSC_IDX_CHANNEL_CONTROL_A: begin
					rd_mux[`DSC_A_EN] = en_ff[s]; // [RQ11]
					rd_mux[`DSC_A_CHANNEL_SOFT_RESET] = rst_busy_ff[s]; // [RQ13]
				end
				`DSC_IDX_CHANNEL_CONTROL_B: begin
					rd_mux[`DSC_B_CMD_LSB+:2] = cmd_ff[s];
					rd_mux[`DSC_B_EVENT_INPUT_ENABLE] = event_input_enable_ff[s];
					rd_mux[`DSC_B_EVENT_ACTION_LSB+:3] = event_action_ff[s];
				end
				`DSC_IDX_BLOCK_TRANSFER_CTL: rd_mux[`DSC_BT_BACT_LSB+:2] = bact_ff[s];
				`DSC_IDX_IRQMASK: rd_mux[`DSC_IRQ_SUSPEND_FLAG] = mask_ff[s];
				`DSC_IDX_IRQFLAG: rd_mux[`DSC_IRQ_SUSPEND_FLAG] = flag_ff[s];
				`DSC_IDX_STATE: begin
					rd_mux[`DSC_ST_DISPEND] = dis_pend_ff[s];
					rd_mux[`DSC_ST_FETCH_ERROR] = fetch_error_ff[s];
					rd_mux[`DSC_ST_SUSPEND_FLAG] = suspend_flag_ff[s];
					rd_mux[`DSC_ST_SKIP] = skip_ff[s];
				end
				default: rd_mux = '0;
			endcase
		end
	end

	// channel select and write-back base; alignment is left to software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chsel_ff <= `DSC_RST_CHSEL;
			wrb_ff <= `DSC_RST_WRB;
		end else if (ce && wr_do) begin
			if (wr_idx == `DSC_IDX_CHSEL && wstrb_ff[0]) begin
				chsel_ff <= wdata_ff[3:0]; // [RQ10]
			end
			if (wr_idx == `DSC_IDX_WRITEBACK_BASE_ADDRESS) begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb_ff[b]) begin
						wrb_ff[8*b+:8] <= wdata_ff[8*b+:8]; // [RQ9]
					end
				end
			end
		end
	end

	// enable, graceful disable, soft reset and suspend state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_ff <= '0;
			dis_pend_ff <= '0;
			suspend_flag_ff <= '0;
			skip_ff <= '0;
			fetch_error_ff <= '0;
			rst_busy_ff <= '0;
			abort_ff <= '0;
		end else if (ce) begin
			abort_ff <= '0;
			for (int i = 0; i < NCH; i++) begin
				if (rst_busy_ff[i]) begin
					rst_busy_ff[i] <= 1'b0; // [RQ13]
					dis_pend_ff[i] <= 1'b0;
					suspend_flag_ff[i] <= 1'b0;
					skip_ff[i] <= 1'b0;
					fetch_error_ff[i] <= 1'b0;
				end else if (wr_a && sel_oh[i] && wdata_ff[`DSC_A_EN]) begin
					en_ff[i] <= 1'b1; // [RQ12]
					dis_pend_ff[i] <= 1'b0;
					fetch_error_ff[i] <= 1'b0;
				end else if (!en_ff[i]) begin
					// a disabled channel holds no suspend state
					suspend_flag_ff[i] <= 1'b0;
					skip_ff[i] <= 1'b0;
					if (wr_a && sel_oh[i] && wdata_ff[`DSC_A_CHANNEL_SOFT_RESET]) begin
						rst_busy_ff[i] <= 1'b1; // [RQ13]
					end
				end else begin
					// the enable bit keeps reading 1 until the burst drains
					if (wr_a && sel_oh[i] && !dis_pend_ff[i]) begin
						dis_pend_ff[i] <= 1'b1; // [RQ11]
					end else if (dis_pend_ff[i] && !burst_busy[i] && buf_empty[i]) begin
						en_ff[i] <= 1'b0; // [RQ11]
						dis_pend_ff[i] <= 1'b0;
						abort_ff[i] <= 1'b1;
					end
					if (go_suspend_flag[i]) begin
						suspend_flag_ff[i] <= 1'b1; // [RQ2] [RQ3] [RQ16]
					end else if (is_resume[i] && suspend_flag_ff[i]) begin
						suspend_flag_ff[i] <= 1'b0; // [RQ5]
					end else if (is_resume[i] && !use_skip[i]) begin
						skip_ff[i] <= 1'b1; // [RQ6]
					end
					if (use_skip[i] && !is_resume[i]) begin
						skip_ff[i] <= 1'b0; // [RQ6]
					end
					if (desc_fetched[i] && !desc_valid[i]) begin
						fetch_error_ff[i] <= 1'b1; // [RQ3]
					end
				end
			end
		end
	end

	// per-channel configuration; command field ignores enable protection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_input_enable_ff <= '0;
			mask_ff <= '0;
			for (int i = 0; i < NCH; i++) begin
				cmd_ff[i] <= DSC_NO_ACTION;
				event_action_ff[i] <= 3'h0;
				bact_ff[i] <= 2'h0;
			end
		end else if (ce) begin
			for (int i = 0; i < NCH; i++) begin
				if (rst_busy_ff[i]) begin
					cmd_ff[i] <= DSC_NO_ACTION;
					event_input_enable_ff[i] <= 1'b0;
					event_action_ff[i] <= 3'h0;
					bact_ff[i] <= 2'h0;
					mask_ff[i] <= 1'b0;
				end else begin
					if (wr_b && sel_oh[i] && wstrb_ff[3]) begin
						cmd_ff[i] <= dsc_cmd_t'(wdata_ff[`DSC_B_CMD_LSB+:2]); // [RQ14]
					end else if (cmd_take[i]) begin
						cmd_ff[i] <= DSC_NO_ACTION; // [RQ15]
					end
					if (wr_b && sel_oh[i] && wstrb_ff[0] && !en_ff[i]) begin
						// channels above the event range keep no event input
						event_input_enable_ff[i] <= (i < NEV) && wdata_ff[`DSC_B_EVENT_INPUT_ENABLE]; // [RQ7]
						event_action_ff[i] <= wdata_ff[`DSC_B_EVENT_ACTION_LSB+:3];
					end
					if (wr_bt && sel_oh[i]) begin
						bact_ff[i] <= wdata_ff[`DSC_BT_BACT_LSB+:2];
					end
					if (wr_mask && sel_oh[i]) begin
						mask_ff[i] <= wdata_ff[`DSC_IRQ_SUSPEND_FLAG];
					end
				end
			end
		end
	end

	// suspend flags: a new suspend wins over the clear-on-read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_ff <= '0;
		end else if (ce) begin
			for (int i = 0; i < NCH; i++) begin
				if (rst_busy_ff[i]) begin
					flag_ff[i] <= 1'b0;
				end else if (go_suspend_flag[i]) begin
					flag_ff[i] <= 1'b1; // [RQ1]
				end else if (rd_clr && sel_oh[i]) begin
					flag_ff[i] <= 1'b0;
				end
			end
		end
	end

	// event triggers only on low channels with input enabled and an action
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_trig_ff <= '0;
		end else if (ce) begin
			for (int i = 0; i < NEV; i++) begin
				ev_trig_ff[i] <= ev_in[i] && event_input_enable_ff[i] && en_ff[i] &&
					(event_action_ff[i] != 3'h0); // [RQ7] [RQ8]
			end
		end
	end

	assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
	assign s_axi_wready = !w_ok_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	// suspended channels still take triggers but are kept out of arbitration
	assign ch_enable = en_ff;
	assign ch_arb_ok = en_ff & ~suspend_flag_ff & ~dis_pend_ff; // [RQ2]
	assign ch_abort = abort_ff;
	assign ev_trig = ev_trig_ff;
	assign writeback_base_address = wrb_ff;
	assign irq = |(flag_ff & mask_ff); // [RQ1]
endmodule

/* dsc_defs.svh */
// register indices, field positions, reset values and codes of the channel control
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
// address width in bits; byte address is four times the register index
`define DSC_AW 10
`define DSC_IDX_CHSEL 8'h3f
`define DSC_IDX_CHANNEL_CONTROL_A 8'h40
`define DSC_IDX_CHANNEL_CONTROL_B 8'h44
`define DSC_IDX_BLOCK_TRANSFER_CTL 8'h48
`define DSC_IDX_WRITEBACK_BASE_ADDRESS 8'h0e
`define DSC_IDX_IRQMASK 8'h4d
`define DSC_IDX_IRQFLAG 8'h4e
`define DSC_IDX_STATE 8'h4f
// channel control a
`define DSC_A_CHANNEL_SOFT_RESET 0
`define DSC_A_EN 1
// channel control b
`define DSC_B_EVENT_ACTION_LSB 0
`define DSC_B_EVENT_INPUT_ENABLE 3
`define DSC_B_CMD_LSB 24
// block transfer control: block action at bits 4:3
`define DSC_BT_BACT_LSB 3
// irq flag and mask: suspend flag
`define DSC_IRQ_SUSPEND_FLAG 2
// channel state
`define DSC_ST_DISPEND 0
`define DSC_ST_FETCH_ERROR 1
`define DSC_ST_SUSPEND_FLAG 2
`define DSC_ST_SKIP 3
// command codes
`define DSC_CMD_NO_ACTION 2'h0
`define DSC_CMD_SUSPEND 2'h1
`define DSC_CMD_RESUME 2'h2
// reset values
`define DSC_RST_CHSEL 4'h0
`define DSC_RST_WRB 32'h0000_0000
// axi responses
`define DSC_RESP_OKAY 2'h0
`define DSC_RESP_SLVERR 2'h2
`endif

/* dsc_pkg.sv */
// types shared by the dma channel suspend control
`include "dsc_defs.svh"
package dsc_pkg;
	typedef enum logic [1:0] {
		DSC_NO_ACTION = `DSC_CMD_NO_ACTION,
		DSC_SUSPEND = `DSC_CMD_SUSPEND,
		DSC_RESUME = `DSC_CMD_RESUME
	} dsc_cmd_t;
	typedef logic [7:0] dsc_idx_t;
endpackage

/* dsc_channel_ctrl_asserts.sv */
// checker of the channel control port relations
`timescale 1ns/100ps
module dsc_channel_ctrl_asserts #(
	parameter int NCH = 16,
	parameter int NEV = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NCH-1:0] burst_busy,
	input wire logic [NCH-1:0] buf_empty,
	input wire logic [NEV-1:0] ev_in,
	input wire logic [NCH-1:0] ch_enable,
	input wire logic [NCH-1:0] ch_arb_ok,
	input wire logic [NCH-1:0] ch_abort,
	input wire logic [NEV-1:0] ev_trig
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_arb_needs_en: assert property ((ch_arb_ok & ~ch_enable) == '0)
		else $error("granted channel not enabled");
	a_abort_drops_en: assert property (ch_abort[0] |-> $past(ch_enable[0]) && !ch_enable[0])
		else $error("abort without enable falling");
	a_abort_pulse: assert property (ch_abort[0] |=> !ch_abort[0])
		else $error("abort longer than one cycle");
	a_abort_when_idle: assert property (ch_abort[0] |-> !$past(burst_busy[0]) && $past(buf_empty[0]))
		else $error("abort before burst drained");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_evtrig_cause: assert property (ev_trig[0] |-> $past(ev_in[0]) && $past(ch_enable[0]))
		else $error("event trigger without cause");
	c_abort: cover property (ch_abort[0]);
	c_suspend: cover property (ch_enable[0] && $fell(ch_arb_ok[0]));
	c_event: cover property (ev_trig[0]);
endmodule

/* dsc_engine_model.sv */
// behavioural dma engine on channel 0: fetches, bursts of three beats every four positions, blocks
`timescale 1ns/100ps
module dsc_engine_model #(
	parameter int NCH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic go,
	input wire logic bad_desc,
	input wire logic [NCH-1:0] ch_arb_ok,
	output logic [NCH-1:0] burst_busy,
	output logic [NCH-1:0] buf_empty,
	output logic [NCH-1:0] burst_end,
	output logic [NCH-1:0] block_end,
	output logic [NCH-1:0] desc_fetched,
	output logic [NCH-1:0] desc_valid,
	output logic [7:0] pos
);
	logic run;
	logic [7:0] pos_ff;
	assign run = go && ch_arb_ok[0];
	// position only moves while granted, so a resume shows where it resumed
	always_ff @(posedge aclk) begin
		if (!aresetn) pos_ff <= 8'h00;
		else if (run) pos_ff <= pos_ff + 8'h01;
	end
	assign pos = pos_ff;
	// buffer drains with the burst, so empty is the inverse of busy
	assign burst_busy = NCH'(run && pos_ff[1:0] != 2'h3);
	assign buf_empty = ~burst_busy;
	assign burst_end = NCH'(run && pos_ff[1:0] == 2'h2);
	assign block_end = NCH'(run && pos_ff[3:0] == 4'he);
	assign desc_fetched = NCH'(run && pos_ff[3:0] == 4'h0);
	assign desc_valid = NCH'(!bad_desc);
endmodule

/* dsc_channel_ctrl_bench.sv */
// bench: register rows, then events, suspend, resume, skip, abort and fetch error
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_channel_ctrl_bench import dsc_pkg::*; ();
	localparam int NCH = 16;
	localparam int NEV = 4;
	typedef struct {dsc_idx_t i; logic [31:0] d; logic [31:0] e;
		logic [1:0] r;} dsc_row_t;
	logic aclk = 1'b0;
	logic aresetn, awv, awr, wv, wr_r, bv, arv, arr, rv, go, bad;
	logic [9:0] aw, ar;
	logic [31:0] wd, rd_d, wrb, d;
	logic [1:0] bresp, rresp, resp;
	logic [NCH-1:0] busy, empty, bend, blk, fet, dval, en, arb, abort;
	logic [NEV-1:0] ev, evt;
	logic [7:0] pos, p;
	logic irq;
	int error_cnt = 0;
	int compares = 0;
	dsc_row_t rows [5] = '{
		'{`DSC_IDX_CHSEL, 32'h5, 32'h5, `DSC_RESP_OKAY},
		'{`DSC_IDX_WRITEBACK_BASE_ADDRESS, 32'h2000_0010, 32'h2000_0010, `DSC_RESP_OKAY},
		'{8'h10, 32'hffff_ffff, 32'h0, `DSC_RESP_SLVERR},
		'{`DSC_IDX_CHSEL, 32'h0, 32'h0, `DSC_RESP_OKAY},
		'{`DSC_IDX_IRQMASK, 32'h4, 32'h4, `DSC_RESP_OKAY}};
	always #5 aclk = ~aclk;
	dsc_channel_ctrl dsc_channel_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
		.ce(1'b1), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(1'b1), .s_axi_araddr(ar), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(1'b1), .burst_busy(busy),
		.buf_empty(empty), .burst_end(bend), .block_end(blk),
		.desc_fetched(fet), .desc_valid(dval), .ev_in(ev), .ch_enable(en),
		.ch_arb_ok(arb), .ch_abort(abort), .ev_trig(evt),
		.writeback_base_address(wrb), .irq(irq));
	dsc_engine_model dsc_engine_model_inst (.aclk(aclk), .aresetn(aresetn),
		.go(go), .bad_desc(bad), .ch_arb_ok(arb), .burst_busy(busy),
		.buf_empty(empty), .burst_end(bend), .block_end(blk),
		.desc_fetched(fet), .desc_valid(dval), .pos(pos));
	task conclude;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// handshakes are judged on values settled at the falling edge, so the
	// edge that launches a ready or valid never races the sampling here
	task wr(input dsc_idx_t i, input logic [31:0] v);
		int n;
		logic a, w, b;
		aw <= {i, 2'h0};
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 50 && !b; n++) begin
			@(negedge aclk);
			a = awr && awv;
			w = wr_r && wv;
			b = bv;
			resp = bresp;
			@(posedge aclk);
			if (a) awv <= 1'b0;
			if (w) wv <= 1'b0;
		end
		if (!b) begin error_cnt++; conclude; end
	endtask
	task rdc(input dsc_idx_t i, input logic [31:0] e);
		int n;
		logic a, r;
		ar <= {i, 2'h0};
		arv <= 1'b1;
		r = 1'b0;
		for (n = 0; n < 50 && !r; n++) begin
			@(negedge aclk);
			a = arr && arv;
			r = rv;
			d = rd_d;
			@(posedge aclk);
			if (a) arv <= 1'b0;
		end
		if (!r) begin error_cnt++; conclude; end
		chk(d, e);
	endtask
	// waits for grant (k 0) or abort (k 1) to reach v; returns at a negedge
	task wfor(input int k, input logic v);
		int n;
		for (n = 0; n < 300; n++) begin
			@(negedge aclk);
			if ((k ? abort[0] : arb[0]) === v) break;
		end
		if (n == 300) begin error_cnt++; conclude; end
	endtask
	initial begin
		{awv, wv, arv, go, bad, aresetn} = '0;
		{ev, aw, ar, wd} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(`DSC_IDX_CHANNEL_CONTROL_A, 32'h0);
		rdc(`DSC_IDX_WRITEBACK_BASE_ADDRESS, `DSC_RST_WRB);
		foreach (rows[k]) begin
			wr(rows[k].i, rows[k].d);
			chk(resp, rows[k].r);
			rdc(rows[k].i, rows[k].e);
		end
		wr(`DSC_IDX_CHANNEL_CONTROL_B, 32'h9);
		rdc(`DSC_IDX_CHANNEL_CONTROL_B, 32'h9);
		wr(`DSC_IDX_CHSEL, 32'h5);
		wr(`DSC_IDX_CHANNEL_CONTROL_B, 32'h9);
		rdc(`DSC_IDX_CHANNEL_CONTROL_B, 32'h1);
		wr(`DSC_IDX_CHSEL, 32'h0);
		wr(`DSC_IDX_CHANNEL_CONTROL_B, 32'h0100_0009);
		rdc(`DSC_IDX_STATE, 32'h0);
		rdc(`DSC_IDX_CHANNEL_CONTROL_B, 32'h9);
		go <= 1'b1;
		wr(`DSC_IDX_CHANNEL_CONTROL_A, 32'h2);
		ev <= 4'h1;
		@(posedge aclk);
		@(negedge aclk);
		chk(evt, 32'h1);
		@(posedge aclk);
		ev <= 4'h0;
		// software suspend, then the channel must stand still
		wr(`DSC_IDX_CHANNEL_CONTROL_B, 32'h0100_0009);
		wfor(0, 1'b0);
		chk(irq, 32'h1);
		chk(en[0], 32'h1);
		p = pos;
		repeat (4) @(negedge aclk);
		chk(pos, p);
		@(posedge aclk);
		rdc(`DSC_IDX_IRQFLAG, 32'h4);
		rdc(`DSC_IDX_IRQFLAG, 32'h0);
		rdc(`DSC_IDX_STATE, 32'h4);
		wr(`DSC_IDX_CHANNEL_CONTROL_B, 32'h0200_0009);
		wfor(0, 1'b1);
		chk(pos, p);
		@(posedge aclk);
		// early resume must swallow the next software suspend
		wr(`DSC_IDX_CHANNEL_CONTROL_B, 32'h0200_0009);
		rdc(`DSC_IDX_STATE, 32'h8);
		wr(`DSC_IDX_CHANNEL_CONTROL_B, 32'h0100_0009);
		repeat (4) @(posedge aclk);
		rdc(`DSC_IDX_STATE, 32'h0);
		wr(`DSC_IDX_BLOCK_TRANSFER_CTL, 32'h10);
		wfor(0, 1'b0);
		chk(pos[3:0], 32'hf);
		chk(en[0], 32'h1);
		@(posedge aclk);
		wr(`DSC_IDX_CHANNEL_CONTROL_A, 32'h0);
		wfor(1, 1'b1);
		chk(en[0], 32'h0);
		@(posedge aclk);
		wr(`DSC_IDX_CHANNEL_CONTROL_A, 32'h1);
		rdc(`DSC_IDX_CHANNEL_CONTROL_B, 32'h0);
		rdc(`DSC_IDX_BLOCK_TRANSFER_CTL, 32'h0);
		bad <= 1'b1;
		wr(`DSC_IDX_CHANNEL_CONTROL_A, 32'h2);
		wfor(0, 1'b0);
		@(posedge aclk);
		rdc(`DSC_IDX_STATE, 32'h6);
		conclude;
	end
endmodule
bind dsc_channel_ctrl dsc_channel_ctrl_asserts #(.NCH(NCH), .NEV(NEV))
	dsc_channel_ctrl_asserts_inst (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .burst_busy(burst_busy),
	.buf_empty(buf_empty), .ev_in(ev_in), .ch_enable(ch_enable),
	.ch_arb_ok(ch_arb_ok), .ch_abort(ch_abort), .ev_trig(ev_trig));
